// >>> logic/spi_irq_regs.svh
`ifndef SPI_IRQ_REGS_SVH
`define SPI_IRQ_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_RX_DATA 8'h08
`define OFF_IEN_SET 8'h14
`define OFF_IEN_CLR 8'h18
`define OFF_MASK_VIEW 8'h1c
`define OFF_RX_PTR 8'h20
`define OFF_RX_CNT 8'h24
`define OFF_EVENT 8'h40
`define OFF_FLAGS 8'h44

// ----------------------------------------
// Source bit positions
// ----------------------------------------
`define BIT_RX_FULL 0
`define BIT_TX_EMPTY 1
`define BIT_MODE_FAULT 2
`define BIT_OVERRUN 3
`define BIT_RX_DONE 4
`define BIT_TX_DONE 5
`define SOURCE_COUNT 6

// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define RST_MASK 6'h00
`define RST_EVENT 6'h00
`define RST_RX_PTR 32'h0000_0000
`define RST_RX_CNT 16'h0000
`define WORD_STEP 32'h0000_0004

`endif

// >>> logic/spi_irq_pkg.sv
package spi_irq_pkg;

  typedef enum logic [0:0] {
    chan_idle = 1'b0,
    chan_write = 1'b1
  } chan_state_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } mem_req_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

endpackage

// >>> logic/rx_channel.sv
`timescale 1ns/100ps
`include "spi_irq_regs.svh"

module rx_channel (
  input wire logic clock,
  input wire logic rst,
  input wire logic load_ptr,
  input wire logic load_cnt,
  input wire logic [31:0] wdata,
  input wire logic rx_full,
  input wire logic [15:0] rx_word,
  input wire logic mem_ready,
  output spi_irq_pkg::mem_req_type mem_req,
  output logic mem_valid,
  output logic [31:0] rx_ptr,
  output logic [15:0] rx_cnt,
  output logic consume
);
  import spi_irq_pkg::*;

  chan_state_type state;
  logic start;

  // ----------------------------------------
  // Transfer start and finish
  // ----------------------------------------
  assign start = (state == chan_idle) && (rx_cnt != 16'h0000) && rx_full; // RULE_08 RULE_09
  assign consume = (state == chan_write) && mem_ready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= chan_idle;
    end else begin
      unique case (state)
        chan_idle: begin
          if (start) begin
            state <= chan_write;
          end
        end
        chan_write: begin
          if (mem_ready) begin
            state <= chan_idle;
          end
        end
      endcase
    end
  end

  // Request held stable until the memory side takes it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_valid <= 1'b0;
      mem_req <= '0;
    end else if (start) begin
      mem_valid <= 1'b1;
      mem_req.addr <= rx_ptr; // RULE_10
      mem_req.data <= rx_word;
    end else if (consume) begin
      mem_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pointer and counter
  // ----------------------------------------
  // A software load wins over an advance in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_ptr <= `RST_RX_PTR; // RULE_06
    end else if (load_ptr) begin
      rx_ptr <= wdata; // RULE_06
    end else if (consume) begin
      rx_ptr <= rx_ptr + `WORD_STEP; // RULE_10
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_cnt <= `RST_RX_CNT; // RULE_07
    end else if (load_cnt) begin
      rx_cnt <= wdata[15:0]; // RULE_07
    end else if (consume && rx_cnt != 16'h0000) begin
      // A count zeroed under a pending write must not wrap
      rx_cnt <= rx_cnt - 16'h0001; // RULE_08 RULE_10
    end
  end

endmodule // rx_channel

// >>> logic/spi_irq_mask_rx_channel.sv
`timescale 1ns/100ps
`include "spi_irq_regs.svh"

// Functional notes
// RULE_01 - Writing one to a bit of the enable-set register enables that source, zeros change nothing.
// RULE_02 - Writing one to a bit of the enable-clear register disables that source, zeros change nothing.
// RULE_03 - The mask view reads one for each enabled source and zero for each disabled one.
// RULE_04 - Set, clear and mask share bit order rx full, tx empty, mode fault, overrun, rx done, tx done.
// RULE_05 - The interrupt request is high while any enabled source has its status bit set.
// RULE_06 - The receive pointer is a 32-bit read/write register reset to zero, loaded by software.
// RULE_07 - The receive counter is bits 15 to 0 of a read/write register reset to zero.
// RULE_08 - With the counter at zero the receive channel makes no transfers.
// RULE_09 - With a nonzero counter a transfer starts whenever the receive-full flag is set.
// RULE_10 - A transfer stores the word at the pointer, adds one word to the pointer, takes one from the count.
// RULE_11 - The receive-done flag follows the channel end-of-transfer level.
// RULE_12 - Receive-full sets when a word enters the receive data register and holds until it is read. The code also clears it when the channel takes the word.
module spi_irq_mask_rx_channel (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic tx_empty_flag,
  input wire logic mode_fault_flag,
  input wire logic tx_channel_done_flag,
  input wire logic mem_ready,
  output spi_irq_pkg::mem_req_type mem_req,
  output logic mem_valid,
  output logic irq
);
  import spi_irq_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  bus_req_type req;
  logic [5:0] mask;
  logic [5:0] event_bits;
  logic [5:0] flags;
  logic [15:0] rx_data;
  logic rx_full_flag;
  logic overrun_flag;
  logic rx_channel_done_flag;
  logic [31:0] rx_ptr;
  logic [15:0] rx_cnt;
  logic consume;
  logic sel_rx_data;
  logic sel_set;
  logic sel_clr;
  logic sel_mask;
  logic sel_ptr;
  logic sel_cnt;
  logic sel_event;
  logic sel_flags;
  logic rx_data_read;
  logic next_rx_full;
  logic next_overrun;
  logic [5:0] next_mask;
  logic [5:0] next_event;
  logic [31:0] next_rdata;

  // Strobes and bit vectors
  logic set_hit;
  logic clr_hit;
  logic event_clr_hit;
  logic ptr_load;
  logic cnt_load;
  logic [5:0] set_bits;
  logic [5:0] clr_bits;
  logic [5:0] event_clr_bits;
  logic rx_full_set;
  logic rx_full_clear;
  logic rx_done_now;
  logic [5:0] pending;
  logic next_irq;

  // Read views
  logic [31:0] view_rx_data;
  logic [31:0] view_mask;
  logic [31:0] view_ptr;
  logic [31:0] view_cnt;
  logic [31:0] view_event;
  logic [31:0] view_flags;

  assign req.addr = bus_addr;
  assign req.wdata = bus_wdata;
  assign req.wr = bus_wr;
  assign req.rd = bus_rd;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Full byte address compare, so misaligned
  // offsets fall through as unmapped
  assign sel_rx_data = (req.addr == `OFF_RX_DATA);
  assign sel_set = (req.addr == `OFF_IEN_SET);
  assign sel_clr = (req.addr == `OFF_IEN_CLR);
  assign sel_mask = (req.addr == `OFF_MASK_VIEW);
  assign sel_ptr = (req.addr == `OFF_RX_PTR);
  assign sel_cnt = (req.addr == `OFF_RX_CNT);
  assign sel_event = (req.addr == `OFF_EVENT);
  assign sel_flags = (req.addr == `OFF_FLAGS);

  assign rx_data_read = req.rd && sel_rx_data;

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  // Bits above the six sources are dropped here,
  // so stray ones never reach a register
  assign set_hit = req.wr && sel_set;
  assign clr_hit = req.wr && sel_clr;
  assign event_clr_hit = req.wr && sel_event;
  assign ptr_load = req.wr && sel_ptr;
  assign cnt_load = req.wr && sel_cnt;
  assign set_bits = set_hit ? req.wdata[5:0] : 6'h00; // RULE_01 RULE_04
  assign clr_bits = clr_hit ? req.wdata[5:0] : 6'h00; // RULE_02 RULE_04
  assign event_clr_bits = event_clr_hit ? req.wdata[5:0] : 6'h00;

  // ----------------------------------------
  // Receive data register
  // ----------------------------------------
  // Only the serializer loads it; an unread word
  // is simply overwritten and counted as overrun
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_data <= 16'h0000;
    end else if (rx_word_valid) begin
      rx_data <= rx_word;
    end
  end

  // A new word in the same cycle as the read keeps
  // the flag set, so no word goes unnoticed
  assign rx_full_set = rx_word_valid; // RULE_12
  assign rx_full_clear = rx_data_read || consume; // RULE_12

  always_comb begin
    next_rx_full = rx_full_flag;
    if (rx_full_clear) begin
      next_rx_full = 1'b0; // RULE_12
    end
    if (rx_full_set) begin
      next_rx_full = 1'b1; // RULE_12
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_full_flag <= 1'b0;
    end else begin
      rx_full_flag <= next_rx_full; // RULE_12
    end
  end

  // ----------------------------------------
  // Overrun detection
  // ----------------------------------------
  // Second load before the first was taken by
  // software or by the channel
  always_comb begin
    next_overrun = 1'b0;
    if (rx_word_valid && rx_full_flag && !rx_data_read && !consume) begin
      next_overrun = 1'b1;
    end
  end

  // Level held until the data register is read, so overrun
  // stays visible in the sticky event register; cleared by reading data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overrun_flag <= 1'b0;
    end else if (next_overrun) begin
      overrun_flag <= 1'b1;
    end else if (rx_data_read) begin
      overrun_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive channel
  // ----------------------------------------
  rx_channel u_rx_channel (
    .clock(clock),
    .rst(rst),
    .load_ptr(ptr_load),
    .load_cnt(cnt_load),
    .wdata(req.wdata),
    .rx_full(rx_full_flag),
    .rx_word(rx_data),
    .mem_ready(mem_ready),
    .mem_req(mem_req),
    .mem_valid(mem_valid),
    .rx_ptr(rx_ptr),
    .rx_cnt(rx_cnt),
    .consume(consume)
  );

  // End of transfer is the count having run out;
  // the count is zero at reset, so the flag rises on the first edge after reset
  assign rx_done_now = (rx_cnt == 16'h0000); // RULE_11

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_channel_done_flag <= 1'b0;
    end else begin
      rx_channel_done_flag <= rx_done_now; // RULE_11
    end
  end

  // ----------------------------------------
  // Source flags
  // ----------------------------------------
  generate
    for (genvar i = 0; i < `SOURCE_COUNT; i++) begin : g_flag
      if (i == `BIT_RX_FULL) begin : g_rf
        assign flags[i] = rx_full_flag; // RULE_04
      end else if (i == `BIT_TX_EMPTY) begin : g_te
        assign flags[i] = tx_empty_flag; // RULE_04
      end else if (i == `BIT_MODE_FAULT) begin : g_mf
        assign flags[i] = mode_fault_flag; // RULE_04
      end else if (i == `BIT_OVERRUN) begin : g_ov
        assign flags[i] = overrun_flag; // RULE_04
      end else if (i == `BIT_RX_DONE) begin : g_rd
        assign flags[i] = rx_channel_done_flag; // RULE_04
      end else begin : g_td
        assign flags[i] = tx_channel_done_flag; // RULE_04
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt enable mask
  // ----------------------------------------
  // Set and clear in the same cycle cannot happen,
  // the bus carries one write at a time
  always_comb begin
    next_mask = mask;
    if (set_hit) begin
      next_mask = mask | set_bits; // RULE_01
    end
    if (clr_hit) begin
      next_mask = mask & ~clr_bits; // RULE_02
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask <= `RST_MASK;
    end else begin
      mask <= next_mask;
    end
  end

  // ----------------------------------------
  // Sticky event status
  // ----------------------------------------
  // Write one to clear; a source still active
  // re-sets its bit at once, set beats clear
  always_comb begin
    next_event = event_bits;
    if (event_clr_hit) begin
      next_event = event_bits & ~event_clr_bits;
    end
    next_event = next_event | flags;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      event_bits <= `RST_EVENT;
    end else begin
      event_bits <= next_event;
    end
  end

  // Built from next values, so the request rises
  // on the same edge as its status bit
  assign pending = next_event & next_mask; // RULE_05
  assign next_irq = |pending; // RULE_05

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq; // RULE_05
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Zero above each register's width, so unused
  // bits can never leak stale state to software
  assign view_rx_data = {16'h0000, rx_data};
  assign view_mask = {26'h000_0000, mask}; // RULE_03 RULE_04
  assign view_ptr = rx_ptr; // RULE_06
  assign view_cnt = {16'h0000, rx_cnt}; // RULE_07
  assign view_event = {26'h000_0000, event_bits};
  assign view_flags = {26'h000_0000, flags};

  // ----------------------------------------
  // Read select
  // ----------------------------------------
  // Write-only and unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (req.rd) begin
      unique case (1'b1)
        sel_rx_data: begin
          next_rdata = view_rx_data;
        end
        sel_mask: begin
          next_rdata = view_mask; // RULE_03
        end
        sel_ptr: begin
          next_rdata = view_ptr; // RULE_06
        end
        sel_cnt: begin
          next_rdata = view_cnt; // RULE_07
        end
        sel_event: begin
          next_rdata = view_event;
        end
        sel_flags: begin
          next_rdata = view_flags;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Data stands for the cycle after each read cycle, zero otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

endmodule // spi_irq_mask_rx_channel

// >>> tb/spi_irq_mask_rx_channel_properties.sv
`timescale 1ns/100ps
`include "spi_irq_regs.svh"
module spi_irq_mask_rx_channel_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic tx_empty_flag,
  input wire logic mem_ready,
  input spi_irq_pkg::mem_req_type mem_req,
  input wire logic mem_valid,
  input wire logic irq
);
  import spi_irq_pkg::*;
  logic [5:0] mask_shadow;
  // ----------------
  // Mask rebuilt from bus writes
  // ----------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_shadow <= `RST_MASK;
    end else if (bus_wr && bus_addr == `OFF_IEN_SET) begin
      mask_shadow <= mask_shadow | bus_wdata[5:0];
    end else if (bus_wr && bus_addr == `OFF_IEN_CLR) begin
      mask_shadow <= mask_shadow & ~bus_wdata[5:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!bus_rd |=> bus_rdata == 32'h0) else $error("read data not idle");
  AST_MASK_READ: assert property (bus_rd && bus_addr == `OFF_MASK_VIEW |=>
    bus_rdata == {26'h0, mask_shadow}) else $error("mask view wrong");
  AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("request not held");
  AST_MEM_DROP: assert property (mem_valid && mem_ready |=> !mem_valid) else $error("request not dropped");
  AST_PTR_STEP: assert property (mem_valid && mem_ready && !bus_wr ##1 !bus_wr ##1 mem_valid |->
    mem_req.addr == $past(mem_req.addr, 2) + 32'h4) else $error("pointer step wrong");
  AST_IRQ_MASKED: assert property (irq |-> mask_shadow != 6'h0) else $error("irq with all masked");
  AST_IRQ_OFF: assert property (bus_wr && bus_addr == `OFF_IEN_CLR && bus_wdata[5:0] == 6'h3f |=> !irq)
    else $error("irq after full disable");
  AST_IRQ_ON: assert property (mask_shadow[1] && tx_empty_flag && !bus_wr |=> irq)
    else $error("irq missing");
endmodule // spi_irq_mask_rx_channel_properties
bind spi_irq_mask_rx_channel spi_irq_mask_rx_channel_properties u_props (.*);

// >>> tb/mem_model.sv
`timescale 1ns/100ps
module mem_model (
  input wire logic clock,
  input wire logic rst,
  input spi_irq_pkg::mem_req_type mem_req,
  input wire logic mem_valid,
  input wire logic [3:0] delay,
  output logic mem_ready,
  output logic [31:0] last_addr,
  output logic [15:0] last_data,
  output logic [7:0] n_writes
);
  import spi_irq_pkg::*;
  logic [3:0] wait_cnt;
  // Programmable wait so slow memory is covered too
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_ready <= 1'b0;
      wait_cnt <= 4'h0;
      n_writes <= 8'h00;
      last_addr <= 32'h0;
      last_data <= 16'h0;
    end else if (mem_valid && mem_ready) begin
      mem_ready <= 1'b0;
      wait_cnt <= 4'h0;
      n_writes <= n_writes + 8'h01;
      last_addr <= mem_req.addr;
      last_data <= mem_req.data;
    end else if (mem_valid && wait_cnt == delay) begin
      mem_ready <= 1'b1;
    end else if (mem_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // mem_model

// >>> tb/spi_irq_mask_rx_channel_tb.sv
`timescale 1ns/100ps
`include "spi_irq_regs.svh"
module spi_irq_mask_rx_channel_tb;
  import spi_irq_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic rx_word_valid = 1'b0;
  logic [15:0] rx_word = 16'h0;
  logic tx_empty_flag = 1'b0;
  logic mode_fault_flag = 1'b0;
  logic tx_channel_done_flag = 1'b0;
  logic mem_ready;
  mem_req_type mem_req;
  logic mem_valid;
  logic irq;
  logic [3:0] delay = 4'h0;
  logic [31:0] last_addr;
  logic [15:0] last_data;
  logic [7:0] n_writes;
  int n_mismatch = 0;
  int n_tests = 0;
  always #2 clock = ~clock;
  spi_irq_mask_rx_channel u_spi_irq_mask_rx_channel (.*);
  mem_model u_mem_model (.*);
  // ----------------
  // Shared tasks
  // ----------------
  task automatic end_sim;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 check("read", bus_rdata, exp);
  endtask
  task automatic word(input logic [15:0] w);
    @(posedge clock);
    rx_word <= w;
    rx_word_valid <= 1'b1;
    @(posedge clock);
    rx_word_valid <= 1'b0;
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_writes(input logic [7:0] n);
    for (int i = 0; i < 40 && n_writes !== n; i++) begin
      @(posedge clock);
    end
    check("writes", 32'(n_writes), 32'(n));
    if (n_writes !== n) end_sim();
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs;
    rd(`OFF_RX_PTR, 32'h0);
    rd(`OFF_RX_CNT, 32'h0);
    rd(`OFF_IEN_SET, 32'h0);
    wr(8'h30, 32'h1);
    rd(8'h30, 32'h0);
    wr(`OFF_RX_PTR, 32'hdead_beef);
    rd(`OFF_RX_PTR, 32'hdead_beef);
    wr(`OFF_RX_CNT, 32'hffff_ffff);
    rd(`OFF_RX_CNT, 32'h0000_ffff);
    wr(`OFF_RX_CNT, 32'h0);
  endtask
  task automatic t_mask;
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++) begin
      m[i] = 1'b1;
      wr(`OFF_IEN_SET, 32'h1 << i);
      rd(`OFF_MASK_VIEW, {26'h0, m});
    end
    wr(`OFF_IEN_SET, 32'hffff_ffc0);
    wr(`OFF_IEN_CLR, 32'hffff_ffc0);
    rd(`OFF_MASK_VIEW, 32'h3f);
    for (int i = 0; i < 6; i++) begin
      m[i] = 1'b0;
      wr(`OFF_IEN_CLR, 32'h1 << i);
      rd(`OFF_MASK_VIEW, {26'h0, m});
    end
  endtask
  task automatic t_irq;
    wr(`OFF_EVENT, 32'h3f);
    @(posedge clock);
    {tx_empty_flag, mode_fault_flag, tx_channel_done_flag} <= 3'h7;
    @(posedge clock);
    {tx_empty_flag, mode_fault_flag, tx_channel_done_flag} <= 3'h0;
    rd(`OFF_EVENT, 32'h36);
    rd(`OFF_FLAGS, 32'h10);
    check("irq", 32'(irq), 32'h0);
    wr(`OFF_IEN_SET, 32'h2);
    #1 check("irq", 32'(irq), 32'h1);
    wr(`OFF_IEN_CLR, 32'h3f);
    #1 check("irq", 32'(irq), 32'h0);
    wr(`OFF_IEN_SET, 32'h2);
    wr(`OFF_EVENT, 32'h2);
    #1 check("irq", 32'(irq), 32'h0);
    @(posedge clock);
    tx_empty_flag <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check("irq", 32'(irq), 32'h1);
    @(posedge clock);
    tx_empty_flag <= 1'b0;
    wr(`OFF_IEN_CLR, 32'h3f);
  endtask
  // Count zero: second word overwrites the first, overrun shows, nothing moves
  task automatic t_rx_idle;
    word(16'h1234);
    word(16'h5678);
    rd(`OFF_FLAGS, 32'h19);
    check("writes", 32'(n_writes), 32'h0);
    rd(`OFF_RX_DATA, 32'h5678);
    rd(`OFF_FLAGS, 32'h10);
  endtask
  // Second word lands in the handshake cycle to force back-to-back
  task automatic t_xfer;
    wr(`OFF_RX_PTR, 32'h100);
    wr(`OFF_RX_CNT, 32'h3);
    word(16'ha001);
    for (int i = 0; i < 20 && mem_valid !== 1'b1; i++) begin
      @(posedge clock);
    end
    check("valid", 32'(mem_valid), 32'h1);
    if (mem_valid !== 1'b1) end_sim();
    rx_word <= 16'hb002;
    rx_word_valid <= 1'b1;
    @(posedge clock);
    rx_word_valid <= 1'b0;
    wait_writes(8'h01);
    check("addr", last_addr, 32'h100);
    check("data", 32'(last_data), 32'ha001);
    wait_writes(8'h02);
    check("addr", last_addr, 32'h104);
    check("data", 32'(last_data), 32'hb002);
    rd(`OFF_RX_CNT, 32'h1);
    delay <= 4'h3;
    word(16'hc003);
    wait_writes(8'h03);
    check("addr", last_addr, 32'h108);
    rd(`OFF_RX_PTR, 32'h10c);
    rd(`OFF_RX_CNT, 32'h0);
    rd(`OFF_FLAGS, 32'h10);
    word(16'hd004);
    repeat (10) @(posedge clock);
    check("writes", 32'(n_writes), 32'h3);
    // Count zeroed while the slow write is pending
    wr(`OFF_RX_CNT, 32'h1);
    wr(`OFF_RX_CNT, 32'h0);
    wait_writes(8'h04);
    check("data", 32'(last_data), 32'hd004);
    rd(`OFF_RX_CNT, 32'h0);
    repeat (10) @(posedge clock);
    check("writes", 32'(n_writes), 32'h4);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_mask();
    t_irq();
    t_rx_idle();
    t_xfer();
    end_sim();
  end
endmodule // spi_irq_mask_rx_channel_tb
